// file: rtl/radio_spi_slave.sv
// SPI mode 0 slave of the radio: register access and frame buffer bursts.
// Assumes serial clock, select and MOSI come from another domain; the radio
// receive stream and status inputs run on clk_in.
`timescale 1ns/10ps
`default_nettype none

module radio_spi_slave
  import radio_spi_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = 2
) (
  input wire logic clk_in,                        // System clock, 50 MHz
  input wire logic nrst_in,                       // Synchronous reset, active low
  input wire logic sclk_in,                       // Serial clock pin
  input wire logic sel_n_in,                      // Chip select pin, active low
  input wire logic mosi_in,                       // Serial data from master
  output logic miso_out,                          // Serial data to master
  output logic miso_oe_n_out,                     // MISO driver enable, active low
  input wire logic [7:0] transceiver_state_in,    // Transceiver state register
  input wire logic [7:0] signal_strength_in,      // Signal strength register
  input wire logic [7:0] irq_status_in,           // Interrupt status register
  input wire logic rx_valid_in,                   // Received byte offered
  input wire rx_byte_t rx_byte_in,                // Received byte and frame start
  output logic rx_ready_out,                      // Receive buffer can take a byte
  output logic reg_wr_out,                        // Register write pulse
  output reg_write_t reg_wr_data_out,             // Register write address and data
  output logic buffer_access_violation_out        // Buffer access violation pulse
);

  localparam int unsigned PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(BUF_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);

  // ==========================================================
  // Pin synchronisers
  logic [1:0] sclk_sync_q, sel_sync_q, mosi_sync_q;
  logic sclk_prev_q, sel_prev_q;
  wire logic sclk_s = sclk_sync_q[1];
  wire logic sel_n_s = sel_sync_q[1];
  wire logic mosi_s = mosi_sync_q[1];
  wire logic sclk_rise = sclk_s && !sclk_prev_q && !sel_n_s;
  wire logic sclk_fall = !sclk_s && sclk_prev_q && !sel_n_s;
  wire logic sel_fell = !sel_n_s && sel_prev_q;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sclk_sync_q <= 2'h0;
      mosi_sync_q <= 2'h0;
      sclk_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end else begin
      sclk_sync_q <= {sclk_sync_q[0], sclk_in};
      mosi_sync_q <= {mosi_sync_q[0], mosi_in};
      sclk_prev_q <= sclk_s;
      sel_prev_q <= sel_n_s;
    end
  end

  // Select keeps running through reset so the driver can follow it
  always_ff @(posedge clk_in) begin
    sel_sync_q <= {sel_sync_q[0], sel_n_in};
  end

  // ==========================================================
  // Storage
  logic [7:0] regs_q [REG_COUNT];
  logic [7:0] fb_mem_q [FB_BYTES];

  // ==========================================================
  // Receive shift and byte framing
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic [7:0] byte_idx_q;
  access_t acc_q;
  logic [5:0] cmd_addr_q;
  logic [7:0] fb_ptr_q;
  logic [7:0] tx_sh_q;
  logic [7:0] tx_next_q;
  logic miso_q, miso_oe_n_q;

  wire logic byte_done = sclk_rise && (bit_cnt_q == 3'd7);
  wire logic [7:0] rx_word = {rx_sh_q[6:0], mosi_s};
  wire logic is_cmd = byte_done && (byte_idx_q == 8'h00);
  wire access_t cmd_acc = decode_cmd(rx_word);
  wire logic is_data = byte_done && (byte_idx_q != 8'h00);
  wire logic reg_wr_hit = is_data && (acc_q == ACC_REG_WR);
  wire logic fb_wr_hit = is_data && (acc_q == ACC_FB_WR);
  wire logic fb_rd_hit = is_data && (acc_q == ACC_FB_RD);
  wire logic fb_busy = !sel_n_s && ((acc_q == ACC_FB_WR) || (acc_q == ACC_FB_RD));

  // Status byte source
  wire stat_mode_t stat_mode = stat_mode_t'(regs_q[CTRL_ONE_ADDR][STAT_SEL_LSB +: 2]);
  wire logic [7:0] stat_byte = (stat_mode == STAT_STATE) ? transceiver_state_in :
                               (stat_mode == STAT_RSSI) ? signal_strength_in :
                               (stat_mode == STAT_IRQ) ? irq_status_in : 8'h00;

  // Next outgoing byte: register content, buffer byte, or don't-care zero
  wire logic [7:0] tx_after_cmd = (cmd_acc == ACC_REG_RD) ? regs_q[rx_word[5:0]] :
                                  (cmd_acc == ACC_FB_RD) ? fb_mem_q[0] : 8'h00;
  wire logic [7:0] tx_after_data = (acc_q == ACC_FB_RD) ? fb_mem_q[fb_ptr_q[6:0]] : 8'h00;
  wire logic [7:0] tx_load = is_cmd ? tx_after_cmd : tx_after_data;

  // Violations: length over range, write past the buffer, read past the trailer
  wire logic [7:0] stored_len = fb_mem_q[0];
  wire logic fb_len_bad = fb_wr_hit && (byte_idx_q == 8'h01) && (rx_word > FRAME_LEN_MAX);
  wire logic fb_wr_over = fb_wr_hit && (fb_ptr_q >= FB_PTR_LIMIT);
  // Legal read bytes are length, payload and trailer: counter may reach length + trailer + 1
  wire logic fb_rd_over = fb_rd_hit && (fb_ptr_q > ({1'b0, stored_len[6:0]} + TRAILER_BYTES + 8'h01));
  wire logic violation = fb_len_bad || fb_wr_over || fb_rd_over;

  always_ff @(posedge clk_in) begin
    if (!nrst_in || sel_n_s) begin
      bit_cnt_q <= 3'd0;
      rx_sh_q <= 8'h00;
      byte_idx_q <= 8'h00;
      acc_q <= ACC_NONE;
      cmd_addr_q <= 6'h00;
    end else if (sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'd1;
      rx_sh_q <= rx_word;
      if (byte_done) begin
        if (byte_idx_q != 8'hff)
          byte_idx_q <= byte_idx_q + 8'h01;
        if (is_cmd) begin
          acc_q <= cmd_acc;
          cmd_addr_q <= rx_word[5:0];
        end else if ((acc_q == ACC_REG_WR) || (acc_q == ACC_REG_RD)) begin
          acc_q <= ACC_NONE;
        end
      end
    end
  end

  // ==========================================================
  // Frame buffer counter
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      fb_ptr_q <= 8'h00;
      tx_next_q <= 8'h00;
    end else if (byte_done) begin
      tx_next_q <= tx_load;
      if (is_cmd)
        fb_ptr_q <= (cmd_acc == ACC_FB_RD) ? 8'h01 : 8'h00;
      else if ((fb_rd_hit || fb_wr_hit) && (fb_ptr_q != 8'hff))
        fb_ptr_q <= fb_ptr_q + 8'h01;
    end
  end

  // ==========================================================
  // MISO shifter and driver enable
  always_ff @(posedge clk_in) begin
    if (!nrst_in || sel_n_s) begin
      tx_sh_q <= 8'h00;
      miso_q <= 1'b0;
    end else if (sel_fell) begin
      tx_sh_q <= stat_byte;
      miso_q <= stat_byte[7];
    end else if (sclk_fall) begin
      if (bit_cnt_q == 3'd0) begin
        tx_sh_q <= tx_next_q;
        miso_q <= tx_next_q[7];
      end else begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        miso_q <= tx_sh_q[6];
      end
    end
  end

  // Driver follows select, also while reset is held
  always_ff @(posedge clk_in) begin
    miso_oe_n_q <= sel_n_s;
  end

  // ==========================================================
  // Receive stream buffer
  rx_byte_t buf_q [BUF_DEPTH];
  logic [PTR_W-1:0] buf_wr_q, buf_rd_q;
  logic [CNT_W-1:0] buf_cnt_q;
  logic rx_ready_q;
  logic [6:0] rx_ptr_q;
  wire logic buf_push = rx_valid_in && rx_ready_q;
  wire logic buf_pop = (buf_cnt_q != '0) && !fb_busy;
  wire rx_byte_t buf_head = buf_q[buf_rd_q];
  wire logic [CNT_W-1:0] buf_cnt_d = buf_cnt_q + CNT_W'(buf_push) - CNT_W'(buf_pop);

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(BUF_DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      buf_wr_q <= '0;
      buf_rd_q <= '0;
      buf_cnt_q <= '0;
      rx_ready_q <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_q[buf_wr_q] <= rx_byte_in;
        buf_wr_q <= ptr_inc(buf_wr_q);
      end
      if (buf_pop)
        buf_rd_q <= ptr_inc(buf_rd_q);
      buf_cnt_q <= buf_cnt_d;
      rx_ready_q <= (buf_cnt_d != CNT_FULL);
    end
  end

  // ==========================================================
  // Frame buffer memory: host writes win, receive drain waits
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rx_ptr_q <= 7'h00;
      for (int i = 0; i < FB_BYTES; i++)
        fb_mem_q[i] <= 8'h00;
    end else if (fb_wr_hit) begin
      if (fb_ptr_q < FB_PTR_LIMIT)
        fb_mem_q[fb_ptr_q[6:0]] <= rx_word;
    end else if (buf_pop) begin
      fb_mem_q[buf_head.first ? 7'h00 : rx_ptr_q] <= buf_head.data;
      rx_ptr_q <= buf_head.first ? 7'h01 : ((rx_ptr_q == 7'h7f) ? rx_ptr_q : rx_ptr_q + 7'h01);
    end
  end

  // ==========================================================
  // Register file
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < REG_COUNT; i++)
        regs_q[i] <= REG_RESET;
    end else if (reg_wr_hit) begin
      regs_q[cmd_addr_q] <= rx_word;
    end
  end

  logic reg_wr_q, viol_q;
  reg_write_t reg_wr_data_q;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      reg_wr_q <= 1'b0;
      reg_wr_data_q <= '0;
      viol_q <= 1'b0;
    end else begin
      reg_wr_q <= reg_wr_hit;
      viol_q <= violation;
      if (reg_wr_hit)
        reg_wr_data_q <= '{addr: cmd_addr_q, data: rx_word};
    end
  end

  assign miso_out = miso_q;
  assign miso_oe_n_out = miso_oe_n_q;
  assign rx_ready_out = rx_ready_q;
  assign reg_wr_out = reg_wr_q;
  assign reg_wr_data_out = reg_wr_data_q;
  assign buffer_access_violation_out = viol_q;

  // ==========================================================
  // Assertions
  miso_float_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    sel_n_s |=> miso_oe_n_q)
    else $error("MISO driven while deselected");
  reset_drive_a: assert property (@(posedge clk_in)
    (!nrst_in && !sel_n_s) |=> !miso_oe_n_q)
    else $error("MISO not driven with select and reset");
  status_zero_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (sel_fell && stat_mode == STAT_ZERO) |=> (tx_sh_q == 8'h00) && !miso_q)
    else $error("Status byte not zero in default mode");
  byte_eight_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (byte_done && !sel_n_s) |=> (bit_cnt_q == 3'd0) && (byte_idx_q == $past(byte_idx_q) + 8'h01))
    else $error("Byte framing not eight bits");
  msb_shift_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (sclk_fall && bit_cnt_q != 3'd0 && !sel_fell) |=> (miso_q == $past(tx_sh_q[6])))
    else $error("MISO not shifted MSB first");
  miso_stable_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!sclk_fall && !sel_fell && !sel_n_s) |=> $stable(miso_q))
    else $error("MISO changed outside a falling edge");
  fb_start_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (is_cmd && cmd_acc == ACC_FB_RD) |=> (fb_ptr_q == 8'h01) && (tx_next_q == $past(fb_mem_q[0])))
    else $error("Buffer read did not start at length byte");
  reg_store_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    reg_wr_hit |=> reg_wr_q && (reg_wr_data_q.addr == $past(cmd_addr_q)) && (regs_q[$past(cmd_addr_q)] == $past(rx_word)))
    else $error("Register write not stored");
  buf_full_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (buf_cnt_q == CNT_FULL) |-> !rx_ready_q)
    else $error("Receive buffer ready while full");

endmodule // radio_spi_slave

`default_nettype wire

// file: inc/radio_spi_pkg.sv
// Constants, types and command decoding for the radio SPI slave.
// Assumes a single 50 MHz system clock shared by every user of the package.
package radio_spi_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned ASYNC_SCLK_MAX_HZ = 7_500_000;
  // Least system cycles per serial clock period in asynchronous operation
  localparam int unsigned SCLK_MIN_CYCLES = (CLK_HZ + ASYNC_SCLK_MAX_HZ - 1) / ASYNC_SCLK_MAX_HZ;

  // ==========================================================
  // Sizes and register layout
  localparam int unsigned REG_COUNT = 64;
  localparam int unsigned FB_BYTES = 128;
  localparam logic [5:0] CTRL_ONE_ADDR = 6'h04;
  localparam int unsigned STAT_SEL_LSB = 2;
  localparam logic [7:0] FRAME_LEN_MAX = 8'h7f;
  localparam logic [7:0] TRAILER_BYTES = 8'h03;
  localparam logic [7:0] FB_PTR_LIMIT = 8'h80;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================
  // Command byte fields
  localparam int unsigned CMD_REG_BIT = 7;
  localparam int unsigned CMD_WR_BIT = 6;
  localparam int unsigned CMD_FB_BIT = 5;

  typedef enum logic [1:0] {STAT_ZERO, STAT_STATE, STAT_RSSI, STAT_IRQ} stat_mode_t;
  typedef enum logic [2:0] {ACC_NONE, ACC_REG_RD, ACC_REG_WR, ACC_FB_RD, ACC_FB_WR} access_t;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
  } reg_write_t;

  // Reserved bits are ignored; SRAM mode decodes to no access
  function automatic access_t decode_cmd(input logic [7:0] cmd);
    if (cmd[CMD_REG_BIT])
      return cmd[CMD_WR_BIT] ? ACC_REG_WR : ACC_REG_RD;
    else if (cmd[CMD_FB_BIT])
      return cmd[CMD_WR_BIT] ? ACC_FB_WR : ACC_FB_RD;
    else
      return ACC_NONE;
  endfunction

endpackage

// file: verif/spi_master_model.sv
// SPI mode 0 master model for the radio slave pins.
// Assumes a 50 MHz bench clock; one serial clock period is 8 cycles.
`timescale 1ns/10ps
`default_nettype none

module spi_master_model (
  input wire logic clk_in,       // Bench clock
  input wire logic miso_in,      // Slave data
  input wire logic miso_oe_n_in, // Slave driver enable, active low
  output logic sclk_out,         // Serial clock, still outside frames
  output logic sel_n_out,        // Chip select, active low
  output logic mosi_out          // Data to slave
);
  logic last_q;
  // A released line reads back as a changing pattern, never the old value
  wire logic line_w = miso_oe_n_in ? ~last_q : miso_in;

  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    mosi_out = 1'b0;
    last_q = 1'b0;
  end

  always @(posedge clk_in) last_q <= line_w;

  task automatic open_x();
    sel_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic close_x();
    repeat (4) @(posedge clk_in);
    sel_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
    repeat (8) @(posedge clk_in);
  endtask

  // Eight full duplex clocks of 160 ns, MSB first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_out <= tx[i];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      rx[i] = line_w;
      sclk_out <= 1'b0;
    end
  endtask
endmodule // spi_master_model

`default_nettype wire

// file: verif/radio_spi_slave_buffer_access_tb.sv
// Self-checking bench of the radio SPI slave: registers, status, buffer, receive stream.
// Assumes the master model drives the serial pins; the bench drives the rest.
`timescale 1ns/10ps
`default_nettype none

module radio_spi_slave_buffer_access_tb;
  import radio_spi_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  wire logic sclk, sel_n, mosi, miso, oe_n, rx_ready, reg_wr, viol;
  logic rx_valid_in = 1'b0;
  rx_byte_t rx_byte_in = '0;
  reg_write_t wr_data, wr_last;
  logic [7:0] st, d;
  logic [7:0] err_total = 8'h00;
  logic [7:0] samples_checked = 8'h00;
  logic [7:0] wr_seen = 8'h00;
  logic [7:0] viol_seen = 8'h00;
  logic [7:0] rx_taken = 8'h00;
  logic [7:0] exp_st [4] = '{8'h00, 8'h11, 8'h22, 8'h33};

  always #10 clk_in = ~clk_in;

  spi_master_model i_spi_master_model (.clk_in(clk_in), .miso_in(miso), .miso_oe_n_in(oe_n),
    .sclk_out(sclk), .sel_n_out(sel_n), .mosi_out(mosi));

  radio_spi_slave #(.BUF_DEPTH(2)) i_radio_spi_slave (.clk_in(clk_in), .nrst_in(nrst_in),
    .sclk_in(sclk), .sel_n_in(sel_n), .mosi_in(mosi), .miso_out(miso), .miso_oe_n_out(oe_n),
    .transceiver_state_in(8'h11), .signal_strength_in(8'h22), .irq_status_in(8'h33),
    .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in), .rx_ready_out(rx_ready),
    .reg_wr_out(reg_wr), .reg_wr_data_out(wr_data), .buffer_access_violation_out(viol));

  always @(posedge clk_in) begin
    if (reg_wr === 1'b1) begin
      wr_seen <= wr_seen + 8'h01;
      wr_last <= wr_data;
    end
    if (viol === 1'b1) viol_seen <= viol_seen + 8'h01;
    if (rx_valid_in && rx_ready === 1'b1) rx_taken <= rx_taken + 8'h01;
  end

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_acc(input logic [7:0] cmd, input logic [7:0] wd);
    i_spi_master_model.open_x();
    i_spi_master_model.xfer(cmd, st);
    i_spi_master_model.xfer(wd, d);
    i_spi_master_model.close_x();
  endtask

  task automatic fb_wr(input logic [7:0] cmd, input logic [7:0] q[$]);
    i_spi_master_model.open_x();
    i_spi_master_model.xfer(cmd, st);
    foreach (q[i]) i_spi_master_model.xfer(q[i], d);
    i_spi_master_model.close_x();
  endtask

  task automatic fb_rd(input logic [7:0] q[$]);
    i_spi_master_model.open_x();
    i_spi_master_model.xfer(8'h20, st);
    foreach (q[i]) begin
      i_spi_master_model.xfer(8'h00, d);
      check("buffer byte", d, q[i]);
    end
    i_spi_master_model.close_x();
  endtask

  task automatic rx_feed();
    logic [7:0] f [6] = '{8'h02, 8'hb1, 8'hb2, 8'hc1, 8'hc2, 8'hc3};
    for (int i = 0; i < 6; i++) begin
      rx_valid_in <= 1'b1;
      rx_byte_in <= {(i == 0), f[i]};
      do @(posedge clk_in); while (rx_ready !== 1'b1);
    end
    rx_valid_in <= 1'b0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 8'h00 && samples_checked > 8'h00) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    test_done();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check("oe idle", {7'h0, oe_n}, 8'h01);
    reg_acc(8'h84, 8'hc3);
    check("status reset", st, 8'h00);
    check("ctrl reset", d, 8'h00);
    reg_acc(8'hff, 8'h5a);
    check("wr pulses", wr_seen, 8'h01);
    check("wr addr", {2'b00, wr_last.addr}, 8'h3f);
    check("wr data", wr_last.data, 8'h5a);
    reg_acc(8'hbf, 8'h00);
    check("read back", d, 8'h5a);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      reg_acc(8'hc4, 8'(m << 2));
      i_spi_master_model.open_x();
      i_spi_master_model.xfer(8'hbf, st);
      check("oe driven", {7'h0, oe_n}, 8'h00);
      i_spi_master_model.xfer(8'h00, d);
      i_spi_master_model.close_x();
      check("status mode", st, exp_st[m]);
    end
    $display("test status done");
    fb_wr(8'h7f, {8'h03, 8'ha1, 8'ha2, 8'ha3});
    fb_rd({8'h03, 8'ha1, 8'ha2, 8'ha3, 8'h00, 8'h00, 8'h00});
    fb_rd({8'h03, 8'ha1});
    fb_rd({8'h03});
    fb_wr(8'h00, {8'h55, 8'h66});
    fb_rd({8'h03, 8'ha1});
    check("no stray writes", wr_seen, 8'h05);
    check("no violation", viol_seen, 8'h00);
    $display("test buffer done");
    i_spi_master_model.open_x();
    i_spi_master_model.xfer(8'h20, st);
    fork
      rx_feed();
    join_none
    repeat (40) @(posedge clk_in);
    check("rx taken held", rx_taken, 8'h02);
    check("rx ready held", {7'h0, rx_ready}, 8'h00);
    i_spi_master_model.close_x();
    for (int k = 0; k < 200 && rx_taken != 8'h06; k++) @(posedge clk_in);
    check("rx taken", rx_taken, 8'h06);
    fb_rd({8'h02, 8'hb1, 8'hb2, 8'hc1, 8'hc2, 8'hc3, 8'h00});
    check("read over", viol_seen, 8'h01);
    fb_wr(8'h60, {8'h80});
    check("violation", viol_seen, 8'h02);
    $display("test receive done");
    i_spi_master_model.open_x();
    nrst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    check("oe in reset", {7'h0, oe_n}, 8'h00);
    i_spi_master_model.close_x();
    check("oe released", {7'h0, oe_n}, 8'h01);
    $display("test reset done");
    test_done();
  end
endmodule // radio_spi_slave_buffer_access_tb

`default_nettype wire
